/* File: core/rx_descriptor_handler.sv */
// Receive descriptor handler: walks the receive ring, fills buffers, writes status back.
// Assumes a 16-bit host memory master port with ready handshake and an Avalon-MM slave for control.
//
// What this block does
// - Neither party touches an entry after giving it up until it returns, save the starvation write-back to a host-owned entry.
// - Error summary bit 14 is OR of alignment, overrun, checksum, starvation faults.
// - Checksum fault bit 11 on bad frame check, last buffer and no overrun.
// - Starvation fault bit 10 when next entry host-owned or overrun before poll.
// - Overrun reported with starvation only when both happen together.
// - First-buffer flag bit 9 written by controller unless software chain mode.
// - Last-buffer flag bit 8 marks final buffer; both flags mean one buffer.
// - Buffer address is word zero plus word one low byte, never altered.
// - Buffers accepted at any byte alignment and any length.
// - Word two bits 11-0 hold negated buffer length, read only by controller.
// - Frame length in word three bits 11-0, unsigned, written on completion.
// - Length counts all bytes including checksum; stripping drops checksum.
// - Word three bits 15-12 are written as zeros.
// - Status byte, upper eight bits of word one, written together.
// - Three-bit size code gives one to 128 entries by doubling.
module rx_descriptor_handler
	import rx_desc_pkg::*;
#(
	parameter int IDX_W = 7
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Host memory master, 16-bit words
	output logic [23:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ready_i,
	// Receive byte stream from the MAC FIFO
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	input wire logic rx_crc_err_i,
	input wire logic rx_odd_bits_i,
	input wire logic rx_fifo_ovf_i,
	output logic rx_ready_o,
	// Byte write into the host buffer
	output logic [23:0] buf_addr_o,
	output logic [7:0] buf_data_o,
	output logic buf_we_o
);
	rx_state_type state_r;
	logic [31:0] ctrl_r;
	logic [23:0] ring_base_r;
	logic [RING_CODE_W-1:0] ring_code_r;
	logic [15:0] word1_r;
	logic [23:0] buf_ptr_r;
	logic [11:0] remain_r;
	logic [11:0] frame_len_r;
	logic in_frame_r;
	logic fresh_r;
	logic frame_done_r;
	logic crc_r;
	logic odd_r;
	logic ovf_r;
	logic starve_r;
	logic [IDX_W-1:0] index;
	logic advance;
	logic [23:0] entry_addr;
	logic bus_acc;
	logic [7:0] status_byte;
	logic frame_crc;
	logic frame_align;
	logic err_sum;

	// Entries are eight bytes apart from the ring base
	assign entry_addr = ring_base_r + 24'(index) * 24'(ENTRY_BYTES);
	assign advance = (state_r == ST_WR1) && mem_ready_i;

	rx_ring_index #(
		.IDX_W(IDX_W)
	) u_index (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.clear_i(!ctrl_r[CTRL_RUN_BIT]),
		.advance_i(advance),
		.size_code_i(ring_code_r),
		.index_o(index)
	);

	// Checksum and alignment terms, valid only for the final buffer of a frame without overrun
	assign frame_crc = frame_done_r && !ovf_r && crc_r;
	assign frame_align = frame_crc && odd_r && !ctrl_r[CTRL_LOOP_BIT];
	assign err_sum = frame_align || ovf_r || frame_crc || starve_r;
	// Status byte assembled as one unit
	always_comb begin
		status_byte = 8'h00;
		status_byte[ERR_BIT-8] = err_sum;
		status_byte[ALIGN_BIT-8] = frame_align;
		status_byte[FIFO_OVERRUN_FAULT_BIT-8] = ovf_r;
		status_byte[CRC_BIT-8] = frame_crc;
		status_byte[STARVE_BIT-8] = starve_r;
		// Driver owns the first flag in software chain mode
		status_byte[FIRST_BIT-8] = ctrl_r[CTRL_SW_CHAIN_BIT] ? word1_r[FIRST_BIT] : !in_frame_r;
		status_byte[LAST_BIT-8] = frame_done_r;
		status_byte[OWN_BIT-8] = 1'b0;
	end

	// Avalon slave: one wait cycle on every access
	assign bus_acc = (avs_read_i || avs_write_i) && avs_waitrequest_o;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
		end
	end

	// Control and ring registers written by software
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= CTRL_RESET_VAL;
			ring_base_r <= 24'h000000;
			ring_code_r <= 3'h0;
		end else if (avs_write_i && bus_acc && avs_byteenable_i[0]) begin
			if (avs_address_i == REG_CTRL_OFS) begin
				ctrl_r <= {24'h000000, avs_writedata_i[7:0]};
			end else if (avs_address_i == REG_RING_OFS) begin
				ring_base_r <= avs_writedata_i[23:0];
				ring_code_r <= avs_writedata_i[30:28];
			end
		end
	end

	// Read data: control, ring setup, state and the byte count of the current or last frame
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0;
		end else if (avs_read_i && bus_acc) begin
			case (avs_address_i)
				REG_CTRL_OFS: avs_readdata_o <= ctrl_r;
				REG_RING_OFS: avs_readdata_o <= {1'b0, ring_code_r, 4'h0, ring_base_r};
				REG_STAT_OFS: avs_readdata_o <= {16'h0, 1'b0, state_r, 5'h0, IDX_W'(index)};
				REG_LEN_OFS: avs_readdata_o <= {20'h0, frame_len_r};
				default: avs_readdata_o <= 32'h0;
			endcase
		end
	end

	// Descriptor walk and status write-back
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			word1_r <= 16'h0;
			buf_ptr_r <= 24'h0;
			remain_r <= 12'h0;
			frame_len_r <= 12'h0;
			in_frame_r <= 1'b0;
			fresh_r <= 1'b1;
			frame_done_r <= 1'b0;
			crc_r <= 1'b0;
			odd_r <= 1'b0;
			ovf_r <= 1'b0;
			starve_r <= 1'b0;
			mem_addr_o <= 24'h0;
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_wdata_o <= 16'h0;
			rx_ready_o <= 1'b0;
			buf_addr_o <= 24'h0;
			buf_data_o <= 8'h00;
			buf_we_o <= 1'b0;
		end else begin
			buf_we_o <= 1'b0;
			if (rx_fifo_ovf_i && in_frame_r && state_r != ST_FILL) begin
				// Overrun before the next entry was polled while chaining
				starve_r <= 1'b1;
				ovf_r <= (state_r == ST_RD1);
			end
			case (state_r)
				ST_IDLE: begin
					if (ctrl_r[CTRL_RUN_BIT]) begin
						mem_addr_o <= entry_addr + 24'(WORD_OFS_1);
						mem_rd_o <= 1'b1;
						state_r <= ST_RD1;
					end
				end
				ST_RD1: begin
					if (mem_ready_i) begin
						word1_r <= mem_rdata_i;
						if (!mem_rdata_i[OWN_BIT]) begin
							// Host still owns it: keep polling, or fault a chained frame
							mem_rd_o <= 1'b0;
							if (in_frame_r) begin
								starve_r <= 1'b1;
								frame_done_r <= 1'b0;
								state_r <= ST_WR3;
							end else begin
								state_r <= ST_IDLE;
							end
						end else begin
							mem_addr_o <= entry_addr;
							state_r <= ST_RD0;
						end
					end
				end
				ST_RD0: begin
					if (mem_ready_i) begin
						// Address taken as is: any byte alignment is fine
						buf_ptr_r <= {word1_r[7:0], mem_rdata_i};
						mem_addr_o <= entry_addr + 24'(WORD_OFS_2);
						state_r <= ST_RD2;
					end
				end
				ST_RD2: begin
					if (mem_ready_i) begin
						// Negate the stored count to get the byte length
						remain_r <= 12'(-mem_rdata_i[11:0]);
						mem_rd_o <= 1'b0;
						rx_ready_o <= (mem_rdata_i[11:0] != 12'h000);
						state_r <= ST_FILL;
					end
				end
				ST_FILL: begin
					if (rx_fifo_ovf_i) begin
						ovf_r <= 1'b1;
						rx_ready_o <= 1'b0;
						frame_done_r <= 1'b0;
						state_r <= ST_WR3;
					end else if (remain_r == 12'h000) begin
						rx_ready_o <= 1'b0;
						frame_done_r <= 1'b0;
						state_r <= ST_WR3;
					end else if (rx_valid_i && rx_ready_o) begin
						buf_addr_o <= buf_ptr_r;
						buf_data_o <= rx_data_i;
						buf_we_o <= 1'b1;
						buf_ptr_r <= buf_ptr_r + 24'h000001;
						remain_r <= remain_r - 12'h001;
						// Count restarts on the first byte of a frame, across all its buffers
						frame_len_r <= fresh_r ? 12'h001 : frame_len_r + 12'h001;
						fresh_r <= 1'b0;
						if (remain_r == 12'h001 || rx_last_i) begin
							rx_ready_o <= 1'b0;
						end
						if (rx_last_i) begin
							frame_done_r <= 1'b1;
							crc_r <= rx_crc_err_i;
							odd_r <= rx_odd_bits_i;
							state_r <= ST_WR3;
						end
					end
				end
				ST_WR3: begin
					// Length first with zero reserved bits; strip drops the checksum
					mem_addr_o <= entry_addr + 24'(WORD_OFS_3);
					mem_wdata_o <= {WORD3_RES_VAL, (frame_done_r && ctrl_r[CTRL_STRIP_BIT]) ?
						frame_len_r - FCS_BYTES : frame_len_r};
					mem_wr_o <= !mem_wr_o || !mem_ready_i;
					if (mem_wr_o && mem_ready_i) begin
						mem_wr_o <= 1'b0;
						state_r <= ST_WR1;
					end
				end
				ST_WR1: begin
					// Status byte and release go last, address byte kept as read
					mem_addr_o <= entry_addr + 24'(WORD_OFS_1);
					mem_wdata_o <= {status_byte, word1_r[7:0]};
					mem_wr_o <= 1'b1;
					if (mem_wr_o && mem_ready_i) begin
						mem_wr_o <= 1'b0;
						state_r <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					// Frame continues into the next buffer unless it ended or faulted
					in_frame_r <= !frame_done_r && !starve_r && !ovf_r;
					if (frame_done_r || starve_r || ovf_r) begin
						fresh_r <= 1'b1;
						frame_done_r <= 1'b0;
						crc_r <= 1'b0;
						odd_r <= 1'b0;
						ovf_r <= 1'b0;
						starve_r <= 1'b0;
					end
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule : rx_descriptor_handler

/* File: pkg/rx_desc_pkg.sv */
// Package for the receive descriptor handler: descriptor field layout and ring constants.
// Assumes 16-bit host memory words and descriptor entries of four words on 8-byte boundaries.
package rx_desc_pkg;
	// Avalon register offsets (byte addresses)
	localparam logic [3:0] REG_CTRL_OFS = 4'h0;
	localparam logic [3:0] REG_RING_OFS = 4'h4;
	localparam logic [3:0] REG_STAT_OFS = 4'h8;
	localparam logic [3:0] REG_LEN_OFS = 4'hc;
	// Control register fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_SW_CHAIN_BIT = 5;
	localparam int CTRL_STRIP_BIT = 6;
	localparam int CTRL_LOOP_BIT = 7;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h0;
	// Word one status bits
	localparam int OWN_BIT = 15;
	localparam int ERR_BIT = 14;
	localparam int ALIGN_BIT = 13;
	localparam int FIFO_OVERRUN_FAULT_BIT = 12;
	localparam int CRC_BIT = 11;
	localparam int STARVE_BIT = 10;
	localparam int FIRST_BIT = 9;
	localparam int LAST_BIT = 8;
	// Word three reserved field
	localparam logic [3:0] WORD3_RES_VAL = 4'h0;
	localparam int RING_CODE_W = 3;
	localparam int ENTRY_BYTES = 8;
	localparam int LEN_W = 12;
	// Stripped trailer: pad removal is not tracked, checksum is four bytes
	localparam logic [11:0] FCS_BYTES = 12'h004;
	localparam logic [3:0] WORD_OFS_1 = 4'h2;
	localparam logic [3:0] WORD_OFS_2 = 4'h4;
	localparam logic [3:0] WORD_OFS_3 = 4'h6;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RD1 = 3'b001,
		ST_RD0 = 3'b010,
		ST_RD2 = 3'b011,
		ST_FILL = 3'b100,
		ST_WR3 = 3'b101,
		ST_WR1 = 3'b110,
		ST_NEXT = 3'b111
	} rx_state_type;
endpackage : rx_desc_pkg

/* File: core/rx_ring_index.sv */
// Ring index counter with power-of-two wrap from a three-bit size code.
// Assumes the size code is steady while the ring is running.
module rx_ring_index
	import rx_desc_pkg::*;
#(
	parameter int IDX_W = 7
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic advance_i,
	input wire logic [RING_CODE_W-1:0] size_code_i,
	output logic [IDX_W-1:0] index_o
);
	logic [IDX_W-1:0] mask;

	// Entry count is one shifted by the code, so last index is count minus one
	assign mask = IDX_W'((1 << size_code_i) - 1);

	// Advance and wrap to the first entry after the last
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index_o <= '0;
		end else if (clear_i) begin
			index_o <= '0;
		end else if (advance_i) begin
			index_o <= (index_o + IDX_W'(1)) & mask;
		end
	end
endmodule : rx_ring_index

/* File: testbench/rx_descriptor_handler_asserts.sv */
// Checker for the receive descriptor handler: write-back content, order and bus timing.
// Assumes it is bound to the top module and sees only its ports.
module rx_descriptor_handler_asserts (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic [23:0] mem_addr_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [15:0] mem_wdata_o,
	input wire logic mem_ready_i
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	// Accepted write-backs of word one and word three
	logic w1;
	logic w3;
	assign w1 = mem_wr_o && mem_ready_i && mem_addr_o[2:0] == 3'h2;
	assign w3 = mem_wr_o && mem_ready_i && mem_addr_o[2:0] == 3'h6;
	sequence len_done;
		w3;
	endsequence
	sequence status_soon;
		##[1:40] w1;
	endsequence
	own_release_a: assert property (w1 |-> !mem_wdata_o[15]) else $error("entry not released");
	err_summary_a: assert property (w1 |-> mem_wdata_o[14] == |mem_wdata_o[13:10])
		else $error("error summary wrong");
	align_cause_a: assert property (w1 && mem_wdata_o[13] |-> mem_wdata_o[11] && mem_wdata_o[8])
		else $error("alignment fault without cause");
	word3_res_a: assert property (w3 |-> mem_wdata_o[15:12] == 4'h0) else $error("reserved bits set");
	host_fields_a: assert property (mem_wr_o |-> mem_addr_o[2:0] inside {3'h2, 3'h6})
		else $error("host field written");
	status_order_a: assert property (len_done |-> status_soon) else $error("status not after length");
	mem_hold_a: assert property ((mem_rd_o || mem_wr_o) && !mem_ready_i |=> $stable(mem_addr_o) && $stable(mem_wr_o))
		else $error("memory request dropped");
	avs_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1
		avs_waitrequest_o) else $error("register answer late");
endmodule : rx_descriptor_handler_asserts
bind rx_descriptor_handler rx_descriptor_handler_asserts chk_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
	.mem_ready_i(mem_ready_i));

/* File: testbench/rx_host_mem_model.sv */
// Host memory model holding the descriptor ring, plus the driver's hand-over of entries.
// Assumes 16-bit words at byte addresses and requests held until ready.
module rx_host_mem_model #(
	parameter logic [23:0] RING_BASE = 24'h000100
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [23:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:2047];
	logic [1:0] wait_cnt;
	logic [1:0] pace;
	// Answers after 0 to 3 cycles; released read data shows the inverse of the last value
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready_o <= 1'b0;
			wait_cnt <= 2'h0;
			pace <= 2'h0;
			rdata_o <= 16'h0;
		end else if (ready_o) begin
			ready_o <= 1'b0;
			rdata_o <= ~rdata_o;
			pace <= pace + 2'h1;
		end else if ((rd_i || wr_i) && wait_cnt == pace) begin
			ready_o <= 1'b1;
			wait_cnt <= 2'h0;
			if (rd_i) rdata_o <= mem[addr_i[11:1]];
			if (wr_i) mem[addr_i[11:1]] <= wdata_i;
		end else if (rd_i || wr_i) wait_cnt <= wait_cnt + 2'h1;
	end
	// Driver hands an entry over only while it holds it; owner bit goes last
	task automatic arm(input int idx, input logic [23:0] buf_a, input logic [11:0] len);
		int w;
		w = int'(RING_BASE >> 1) + idx * 4; // Entries on 8-byte boundaries
		mem[w] = buf_a[15:0];
		mem[w + 2] = {4'hf, 12'h000 - len};
		mem[w + 3] = 16'h0;
		mem[w + 1] = {8'h80, buf_a[23:16]};
	endtask : arm
endmodule : rx_host_mem_model

/* File: testbench/test_rx_descriptor_handler.sv */
// Testbench for the receive descriptor handler: register access, frames, status write-back.
// Assumes the host memory model answers the descriptor port and the checker is bound.
module test_rx_descriptor_handler
	import rx_desc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] RING_BASE = 24'h000100;
	localparam logic [23:0] BUF0 = 24'h000403;
	localparam int DESC0 = 'h80;
	localparam logic [4:0] MODES [7] = '{5'h00, 5'h0c, 5'h0a, 5'h04, 5'h0d, 5'h10, 5'h00};
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic avs_waitrequest_o, mem_rd_o, mem_wr_o, mem_ready_i, rx_ready_o, buf_we_o;
	logic [23:0] mem_addr_o, buf_addr_o;
	logic [15:0] mem_wdata_o, mem_rdata_i;
	logic rx_valid_i = 1'b0, rx_last_i = 1'b0, rx_crc_err_i = 1'b0, rx_odd_bits_i = 1'b0;
	logic [7:0] rx_data_i = 8'h0, buf_data_o;
	logic [31:0] seed = 32'h34b28db2, rd_d;
	logic [31:0] bq [$];
	logic chk_buf = 1'b0;
	logic ovf = 1'b0;
	int failures = 0, comparisons = 0, e = 0;
	rx_descriptor_handler dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i), .mem_ready_i(mem_ready_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.rx_last_i(rx_last_i), .rx_crc_err_i(rx_crc_err_i), .rx_odd_bits_i(rx_odd_bits_i), .rx_fifo_ovf_i(ovf),
		.rx_ready_o(rx_ready_o), .buf_addr_o(buf_addr_o), .buf_data_o(buf_data_o), .buf_we_o(buf_we_o));
	rx_host_mem_model #(.RING_BASE(RING_BASE)) host_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i),
		.ready_o(mem_ready_i));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run
	// One register access, held until waitrequest is seen low
	task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (avs_waitrequest_o !== 1'b0) failures++;
		rd_d = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : avs
	// One byte, held until taken; valid stays up between bytes of a frame
	task automatic send(input logic [7:0] b, input logic last, input logic crc, input logic odd);
		int n;
		n = 0;
		rx_valid_i <= 1'b1;
		rx_data_i <= b;
		rx_last_i <= last;
		rx_crc_err_i <= crc;
		rx_odd_bits_i <= odd;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (rx_ready_o !== 1'b1 && n < 400);
		if (rx_ready_o !== 1'b1) failures++;
		if (last) rx_valid_i <= 1'b0;
	endtask : send
	// Overrun pulse while the first buffer waits for bytes
	task automatic overrun;
		avs(1'b1, REG_CTRL_OFS, 32'h1);
		repeat (40) @(posedge clk_sys_i);
		ovf <= 1'b1;
		@(posedge clk_sys_i);
		ovf <= 1'b0;
		for (int n = 0; n < 400 && host_u.mem[DESC0 + 4 * e + 1][OWN_BIT] !== 1'b0; n++) @(posedge clk_sys_i);
		check({16'h0, host_u.mem[DESC0 + 4 * e + 1]}, {16'h0, 8'h52, BUF0[23:16]});
		host_u.arm(e, BUF0 + 24'(e * 32), 12'h8);
		e = (e + 1) % 2;
	endtask : overrun
	// Mode bits: software chain, checksum error, odd bits, stripping, loopback
	task automatic frame(input logic [4:0] m);
		int len;
		int nb;
		int le;
		seed = lfsr(seed);
		len = m[1] ? 5 + int'(seed % 3) : 1 + int'(seed % 15);
		if (len == 8) len = 9;
		nb = (len > 8) ? 2 : 1;
		le = (e + nb - 1) % 2;
		chk_buf = 1'b1;
		avs(1'b1, REG_CTRL_OFS, {24'h0, m[0], m[1], m[4], 4'h0, 1'b1});
		for (int k = 0; k < len; k++) begin
			seed = lfsr(seed);
			bq.push_back({BUF0 + 24'((e + k / 8) % 2 * 32 + k % 8), seed[7:0]});
			send(seed[7:0], k == len - 1, m[3], m[2]);
		end
		for (int n = 0; n < 400 && host_u.mem[DESC0 + 4 * le + 1][OWN_BIT] !== 1'b0; n++) @(posedge clk_sys_i);
		if (nb == 2) check({16'h0, host_u.mem[DESC0 + 4 * e + 1]}, {16'h0, m[4] ? 8'h00 : 8'h02, BUF0[23:16]});
		check({16'h0, host_u.mem[DESC0 + 4 * le + 1]}, {16'h0, 1'b0, m[3], m[3] & m[2] & !m[0], 1'b0, m[3], 1'b0,
			nb == 1 && !m[4], 1'b1, BUF0[23:16]});
		check({16'h0, host_u.mem[DESC0 + 4 * le + 3]}, {20'h0, 12'(m[1] ? len - 4 : len)});
		avs(1'b0, REG_LEN_OFS, 32'h0);
		check(rd_d, 32'(len));
		if (chk_buf) check(32'(bq.size()), 32'h0);
		bq.delete();
		for (int j = 0; j < nb; j++) host_u.arm((e + j) % 2, BUF0 + 24'((e + j) % 2 * 32), 12'h8);
		e = (e + nb) % 2;
	endtask : frame
	// Buffer bytes land at the expected address in arrival order
	always @(posedge clk_sys_i) begin
		if (buf_we_o === 1'b1 && chk_buf && bq.size() > 0) check({buf_addr_o, buf_data_o}, bq.pop_front());
	end
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Main sequence: ring setup, register read-back, a table of frame kinds
	initial begin
		for (int i = 0; i < 2; i++) host_u.arm(i, BUF0 + 24'(i * 32), 12'h8);
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		avs(1'b1, REG_RING_OFS, {1'b0, 3'h1, 4'h0, RING_BASE});
		avs(1'b0, REG_RING_OFS, 32'h0);
		check(rd_d, {1'b0, 3'h1, 4'h0, RING_BASE});
		avs(1'b0, 4'h1, 32'h0);
		check(rd_d, 32'h0);
		for (int f = 0; f < 7; f++) begin
			if (f == 3) overrun;
			frame(MODES[f]);
		end
		complete_run;
	end
	// Watchdog against a hang
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		failures++;
		complete_run;
	end
endmodule : test_rx_descriptor_handler
